// ==== pkg/dets_pkg.sv ====
// Purpose: Shared constants and types for the EDO timing / parity config block
// Assumes: 8-bit register port, one 200 MHz clock, T = one clock
// Notes:   Reset values are all zero
`default_nettype none
package dets_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] DETS_OFF_AUX_CONFIG  = 8'h70;
  localparam logic [7:0] DETS_OFF_STATUS      = 8'h71;
  localparam logic [7:0] DETS_OFF_EDO_TIMING  = 8'h7c;
  localparam logic [7:0] DETS_OFF_PAR_DISABLE = 8'h7d;
  localparam logic [7:0] DETS_OFF_BANK_TYPE   = 8'h7e;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] DETS_RST_AUX_CONFIG  = 8'h00;
  localparam logic [7:0] DETS_RST_EDO_TIMING  = 8'h00;
  localparam logic [7:0] DETS_RST_PAR_DISABLE = 8'h00;
  localparam logic [7:0] DETS_RST_BANK_TYPE   = 8'h00;
  // ----------------------------------------
  // Strobe timing control fields
  // ----------------------------------------
  localparam int DETS_B_POP_ALIGN   = 7;
  localparam int DETS_B_WR_WIDTH_EN = 6;
  localparam int DETS_B_LATCH_SYNC  = 5;
  localparam int DETS_B_WR_WIDTH    = 4;
  localparam int DETS_B_LATCH_HIGH  = 3;
  localparam int DETS_B_SRAM_WR4    = 2;
  localparam int DETS_B_RD_WIDTH    = 1;
  localparam int DETS_B_PRECHARGE   = 0;
  // ----------------------------------------
  // Aux config fields
  // ----------------------------------------
  localparam int DETS_B_PAR_GLOBAL_OFF = 0;
  localparam int DETS_B_PAR_BANK_EN    = 1;
  localparam int DETS_LSB_LATCH_TIME   = 2;
  localparam int DETS_LSB_SRAM_FIRST   = 4;
  localparam logic [1:0] DETS_SRAM_FIRST_3T = 2'h2;
  // ----------------------------------------
  // Timing counts in clocks
  // ----------------------------------------
  localparam logic [1:0] DETS_ONE_T   = 2'h1;
  localparam logic [1:0] DETS_TWO_T   = 2'h2;
  localparam logic [1:0] DETS_FP_CAS  = 2'h2;
  localparam logic [1:0] DETS_FP_PRE  = 2'h2;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {DETS_IDLE, DETS_CAS, DETS_PRE} dets_state_t;
  typedef struct packed {
    logic       write;
    logic [2:0] bank;
    logic [1:0] beats;
  } dets_req_t;
endpackage
`default_nettype wire

// ==== test/dets_cfg_bench.sv ====
// Purpose: Self-checking bench for dets_cfg
// Assumes: 200 MHz clock, one-cycle register strobes
// Notes:   Memory stand-in measures strobe widths
`default_nettype none
module dets_cfg_bench
  import dets_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_clock = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_req = 1'b0, bad = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, o_bank_parity_enable;
  dets_req_t  i_req_info = '0;
  logic       o_busy, o_done, o_col_strobe_n, o_data_buffer_pop_strobe, o_memory_data_latch_enable;
  logic       i_parity_fail, o_parity_error, o_sram_write_first_4t, perr;
  logic [3:0] low_len, pop_ofs, latch_ofs;
  int         fail_count = 0, checked = 0;
  dets_cfg dut (.i_clock, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_req, .i_req_info, .o_busy,
    .o_done, .o_col_strobe_n, .o_data_buffer_pop_strobe, .o_memory_data_latch_enable, .i_parity_fail,
    .o_bank_parity_enable, .o_parity_error, .o_sram_write_first_4t);
  dets_mem_model mem (.i_clock, .i_cas_n(o_col_strobe_n), .i_pop(o_data_buffer_pop_strobe),
    .i_latch(o_memory_data_latch_enable), .i_bad_parity(bad), .o_parity_fail(i_parity_fail),
    .o_low_len(low_len), .o_pop_ofs(pop_ofs), .o_latch_ofs(latch_ofs));
  initial begin
    forever #2.5 i_clock = ~i_clock;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 chk("rdata", e, o_rdata);
  endtask
  // Two-column access; waits for done under a bound
  task automatic acc(input logic w, input logic [2:0] b, input logic [3:0] lo, input logic [3:0] po, input logic pe);
    int n;
    n = 0;
    perr = 1'b0;
    @(posedge i_clock);
    i_req <= 1'b1;
    i_req_info <= '{write: w, bank: b, beats: 2'h1};
    @(posedge i_clock);
    i_req <= 1'b0;
    do begin
      @(posedge i_clock);
      #1 perr |= (o_parity_error === 1'b1);
      n++;
    end while (o_done !== 1'b1 && n < 60);
    chk("done", 8'h01, {7'h0, o_done});
    chk("busy", 8'h00, {7'h0, o_busy});
    chk("strobe_low", {4'h0, lo}, {4'h0, low_len});
    chk("pop_offset", {4'h0, po}, {4'h0, pop_ofs});
    chk("parity_err", {7'h0, pe}, {7'h0, perr});
  endtask
  task automatic cas_case(input logic [7:0] c, input logic w, input logic [2:0] b, input logic [3:0] lo, po);
    wr(DETS_OFF_EDO_TIMING, c);
    acc(w, b, lo, po, 1'b0);
  endtask
  task automatic t_regs();
    rd(DETS_OFF_EDO_TIMING, DETS_RST_EDO_TIMING);
    rd(DETS_OFF_PAR_DISABLE, DETS_RST_PAR_DISABLE);
    rd(DETS_OFF_BANK_TYPE, DETS_RST_BANK_TYPE);
    wr(8'h55, 8'h3c);
    rd(8'h55, 8'h00);
    wr(DETS_OFF_BANK_TYPE, 8'ha5);
    rd(DETS_OFF_BANK_TYPE, 8'ha5);
  endtask
  task automatic t_width();
    wr(DETS_OFF_BANK_TYPE, 8'h01);
    cas_case(8'h00, 1'b0, 3'h0, 4'h2, 4'h1);
    cas_case(8'h83, 1'b0, 3'h0, 4'h1, 4'h0);
    cas_case(8'h10, 1'b1, 3'h0, 4'h1, 4'h1);
    wr(DETS_OFF_AUX_CONFIG, 8'h08);
    cas_case(8'h50, 1'b1, 3'h0, 4'h2, 4'h1);
    chk("latch_ofs", 8'h02, {4'h0, latch_ofs});
    cas_case(8'h60, 1'b1, 3'h0, 4'h1, 4'h1);
    chk("latch_ofs", 8'h00, {4'h0, latch_ofs});
    cas_case(8'h83, 1'b0, 3'h1, 4'h2, 4'h0);
  endtask
  task automatic t_latch();
    wr(DETS_OFF_EDO_TIMING, 8'h08);
    @(posedge i_clock);
    #1 chk("latch", 8'h01, {7'h0, o_memory_data_latch_enable});
    wr(DETS_OFF_EDO_TIMING, 8'h00);
    repeat (2) @(posedge i_clock);
    #1 chk("latch", 8'h00, {7'h0, o_memory_data_latch_enable});
  endtask
  task automatic t_parity();
    @(posedge i_clock);
    #1 chk("par_en", 8'hff, o_bank_parity_enable);
    wr(DETS_OFF_AUX_CONFIG, 8'h01);
    @(posedge i_clock);
    #1 chk("par_en", 8'h00, o_bank_parity_enable);
    wr(DETS_OFF_AUX_CONFIG, 8'h03);
    wr(DETS_OFF_PAR_DISABLE, 8'h02);
    @(posedge i_clock);
    #1 chk("par_en", 8'hfd, o_bank_parity_enable);
    @(posedge i_clock);
    bad <= 1'b1;
    acc(1'b0, 3'h1, 4'h2, 4'h1, 1'b0);
    acc(1'b1, 3'h2, 4'h2, 4'h1, 1'b1);
    @(posedge i_clock);
    bad <= 1'b0;
    rd(DETS_OFF_STATUS, 8'h02);
    rd(DETS_OFF_AUX_CONFIG, 8'h03);
  endtask
  task automatic t_sram();
    wr(DETS_OFF_AUX_CONFIG, 8'h20);
    wr(DETS_OFF_EDO_TIMING, 8'h04);
    #1 chk("sram_4t", 8'h01, {7'h0, o_sram_write_first_4t});
    wr(DETS_OFF_AUX_CONFIG, 8'h10);
    #1 chk("sram_4t", 8'h00, {7'h0, o_sram_write_first_4t});
  endtask
  task automatic tally_and_finish();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Whole run needs well under 1000 cycles
  initial begin
    repeat (4000) @(posedge i_clock);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    t_regs();
    t_width();
    t_latch();
    t_parity();
    t_sram();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== test/dets_cfg_props.sv ====
// Purpose: Port checker for dets_cfg
// Assumes: Shadow registers follow bus writes
// Notes:   Bound to every dets_cfg instance
`default_nettype none
module dets_cfg_props
  import dets_pkg::*;
(
  input wire logic       i_clock, i_rst, i_wr, i_rd, i_req, i_parity_fail,
  input wire logic       o_busy, o_done, o_col_strobe_n, o_data_buffer_pop_strobe,
  input wire logic       o_memory_data_latch_enable, o_parity_error, o_sram_write_first_4t,
  input wire logic [7:0] i_addr, i_wdata, o_rdata, o_bank_parity_enable,
  input wire dets_req_t  i_req_info
);
  logic [7:0] t, ax, pd, ty, pe;
  logic       edo, wr, cas2, pre1;
  logic [2:0] bk;
  always_ff @(posedge i_clock) begin
    if (i_rst) {t, ax, pd, ty} <= '0;
    else if (i_wr) case (i_addr)
      DETS_OFF_EDO_TIMING:  t  <= i_wdata;
      DETS_OFF_AUX_CONFIG:  ax <= i_wdata;
      DETS_OFF_PAR_DISABLE: pd <= i_wdata;
      DETS_OFF_BANK_TYPE:   ty <= i_wdata;
      default: ;
    endcase
  end
  // Bank type is frozen at request time, as the design does
  always_ff @(posedge i_clock) begin
    if (i_req && !o_busy) {edo, wr, bk} <= {ty[i_req_info.bank], i_req_info.write, i_req_info.bank};
  end
  assign cas2 = !edo || (wr ? (t[6] && t[4]) : !t[1]);
  assign pre1 = edo && t[0];
  assign pe   = !ax[0] ? 8'hff : (ax[1] ? ~pd : 8'h00);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  pop_same_a:
    assert property ($fell(o_col_strobe_n) |-> o_data_buffer_pop_strobe == t[7]) else $error("pop placement");
  pop_late_a:
    assert property ($fell(o_col_strobe_n) && !t[7] |=> o_data_buffer_pop_strobe) else $error("pop late");
  cas_short_a:
    assert property ($fell(o_col_strobe_n) && !cas2 |=> o_col_strobe_n) else $error("strobe not 1T");
  cas_long_a:
    assert property ($fell(o_col_strobe_n) && cas2 |=> !o_col_strobe_n ##1 o_col_strobe_n) else $error("strobe not 2T");
  pre_short_a:
    assert property ($rose(o_col_strobe_n) && o_busy && pre1 |=> !o_col_strobe_n || o_done) else $error("pre not 1T");
  pre_long_a:
    assert property ($rose(o_col_strobe_n) && o_busy && !pre1 |=> o_col_strobe_n && o_busy ##1 (!o_col_strobe_n || o_done))
      else $error("pre not 2T");
  latch_sync_a:
    assert property ($fell(o_col_strobe_n) && edo && wr && t[5] |-> o_memory_data_latch_enable) else $error("latch late");
  latch_test_a:
    assert property (t[3] |=> o_memory_data_latch_enable) else $error("latch not forced");
  sram_first_a:
    assert property (o_sram_write_first_4t == (t[2] && ax[5:4] == DETS_SRAM_FIRST_3T)) else $error("sram first");
  par_enable_a:
    assert property (1 |=> o_bank_parity_enable == $past(pe)) else $error("parity enables");
  par_error_a:
    assert property (1 |=> o_parity_error == $past(o_busy && i_parity_fail && o_bank_parity_enable[bk]))
      else $error("parity error");
  type_read_a:
    assert property (i_rd && i_addr == DETS_OFF_BANK_TYPE |=> o_rdata == ty) else $error("type readback");
  cover property ($fell(o_col_strobe_n) && edo && !wr);
  cover property ($fell(o_col_strobe_n) && edo && wr);
  cover property (o_parity_error);
endmodule
bind dets_cfg dets_cfg_props u_props (.i_clock, .i_rst, .i_wr, .i_rd, .i_req, .i_parity_fail, .o_busy, .o_done,
  .o_col_strobe_n, .o_data_buffer_pop_strobe, .o_memory_data_latch_enable, .o_parity_error,
  .o_sram_write_first_4t, .i_addr, .i_wdata, .o_rdata, .o_bank_parity_enable, .i_req_info);
`default_nettype wire

// ==== test/dets_mem_model.sv ====
// Purpose: DRAM bank and data buffer stand-in
// Assumes: One column strobe, active low
// Notes:   Reports last strobe width, pop offset and latch offset
`default_nettype none
module dets_mem_model (
  // From the controller and bench
  input  wire logic       i_clock,
  input  wire logic       i_cas_n,
  input  wire logic       i_pop,
  input  wire logic       i_latch,
  input  wire logic       i_bad_parity,
  // To controller and bench
  output logic            o_parity_fail,
  output logic      [3:0] o_low_len,
  output logic      [3:0] o_pop_ofs,
  output logic      [3:0] o_latch_ofs
);
  logic [3:0] run_reg = 4'h0;
  // Parity is only judged while a column is open
  assign o_parity_fail = i_bad_parity && !i_cas_n;
  always_ff @(posedge i_clock) begin
    run_reg <= i_cas_n ? 4'h0 : run_reg + 4'h1;
    if (i_cas_n && run_reg != 4'h0) o_low_len <= run_reg;
    if (i_pop) o_pop_ofs <= run_reg;
    if (i_latch) o_latch_ofs <= run_reg;
  end
endmodule
`default_nettype wire

// ==== verilog/dets_cfg.sv ====
// Purpose: EDO column strobe timing, latch/pop placement and bank parity config
// Assumes: Requests only taken while idle; inputs synchronous to i_clock
// Notes:   One column access sequencer drives the strobes from the settings
//
// The implementer's own choice: the strobed register port.
`default_nettype none
module dets_cfg
  import dets_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Access request
  input  wire logic       i_req,
  input  wire dets_req_t  i_req_info,
  output logic            o_busy,
  output logic            o_done,
  // Memory strobes
  output logic            o_col_strobe_n,
  output logic            o_data_buffer_pop_strobe,
  output logic            o_memory_data_latch_enable,
  // Parity
  input  wire logic       i_parity_fail,
  output logic      [7:0] o_bank_parity_enable,
  output logic            o_parity_error,
  // Cache timing
  output logic            o_sram_write_first_4t
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]  edo_strobe_timing_control_reg;
  logic [7:0]  bank_parity_disable_reg;
  logic [7:0]  bank_dram_type_select_reg;
  logic [7:0]  aux_config_reg;
  logic [7:0]  rdata_reg;

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  dets_state_t state_reg;
  dets_req_t   req_reg;
  logic        edo_reg;
  logic [1:0]  cnt_reg;
  logic [1:0]  phase_reg;
  logic        pop_reg;
  logic        latch_reg;
  logic        done_reg;

  // ----------------------------------------
  // Parity state
  // ----------------------------------------
  logic [7:0]  par_en_reg;
  logic        par_err_reg;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Aux holds the outside settings that these bits refer to
  // Status is read-only: a write to it falls into the default arm
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      edo_strobe_timing_control_reg <= DETS_RST_EDO_TIMING;
      bank_parity_disable_reg       <= DETS_RST_PAR_DISABLE;
      bank_dram_type_select_reg     <= DETS_RST_BANK_TYPE;
      aux_config_reg                <= DETS_RST_AUX_CONFIG;
    end else if (i_wr) begin
      unique case (i_addr)
        DETS_OFF_EDO_TIMING:  edo_strobe_timing_control_reg <= i_wdata;
        DETS_OFF_PAR_DISABLE: bank_parity_disable_reg       <= i_wdata;
        DETS_OFF_BANK_TYPE:   bank_dram_type_select_reg     <= i_wdata;
        DETS_OFF_AUX_CONFIG:  aux_config_reg                <= i_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Read data stands one cycle only; unmapped offsets read as zero
  logic [7:0] status_val;
  assign status_val = {5'h00, edo_reg, req_reg.write, state_reg != DETS_IDLE};

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        DETS_OFF_EDO_TIMING:  rdata_reg <= edo_strobe_timing_control_reg;
        DETS_OFF_PAR_DISABLE: rdata_reg <= bank_parity_disable_reg;
        DETS_OFF_BANK_TYPE:   rdata_reg <= bank_dram_type_select_reg;
        DETS_OFF_AUX_CONFIG:  rdata_reg <= aux_config_reg;
        DETS_OFF_STATUS:      rdata_reg <= status_val;
        default:              rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // ----------------------------------------
  // Timing selection
  // ----------------------------------------
  logic       start;
  logic       req_edo;
  logic [1:0] cas_len;
  logic [1:0] pre_len;
  logic [1:0] lat_delay;
  logic [1:0] cfg_latch_time;
  logic       wr_2t;

  // A request while busy is dropped; the caller waits for o_done
  assign start          = i_req && (state_reg == DETS_IDLE);
  assign req_edo        = bank_dram_type_select_reg[i_req_info.bank];
  assign cfg_latch_time = aux_config_reg[DETS_LSB_LATCH_TIME +: 2];
  assign wr_2t          = edo_strobe_timing_control_reg[DETS_B_WR_WIDTH_EN]
                        & edo_strobe_timing_control_reg[DETS_B_WR_WIDTH];

  // Width and precharge come from the bank type frozen at request,
  // so a type change during an access cannot split one column
  always_comb begin
    if (!edo_reg) begin
      cas_len = DETS_FP_CAS;
      pre_len = DETS_FP_PRE;
    end else begin
      if (req_reg.write) begin
        cas_len = wr_2t ? DETS_TWO_T : DETS_ONE_T;
      end else begin
        cas_len = edo_strobe_timing_control_reg[DETS_B_RD_WIDTH] ? DETS_ONE_T : DETS_TWO_T;
      end
      pre_len = edo_strobe_timing_control_reg[DETS_B_PRECHARGE] ? DETS_ONE_T : DETS_TWO_T;
    end
  end

  // Latch placement uses the request fields at start, the latched ones later
  logic lat_write;
  logic lat_edo;
  assign lat_write = start ? i_req_info.write : req_reg.write;
  assign lat_edo   = start ? req_edo : edo_reg;
  assign lat_delay = (lat_edo && lat_write && edo_strobe_timing_control_reg[DETS_B_LATCH_SYNC])
                   ? 2'h0 : cfg_latch_time;

  // ----------------------------------------
  // Column access sequencer
  // ----------------------------------------
  // A column starts on a taken request or after a precharge with beats left
  logic cas_start;
  assign cas_start = start || (state_reg == DETS_PRE && cnt_reg == DETS_ONE_T && req_reg.beats != 2'h0);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= DETS_IDLE;
      req_reg   <= '0;
      edo_reg   <= 1'b0;
      cnt_reg   <= 2'h0;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        DETS_IDLE: begin
          if (start) begin
            req_reg   <= i_req_info;
            edo_reg   <= req_edo;
            state_reg <= DETS_CAS;
            cnt_reg   <= 2'h0;
          end
        end
        DETS_CAS: begin
          // Count was loaded late, so compare the count plus entry cycle against the length
          if (cnt_reg + 2'h1 >= cas_len) begin
            state_reg <= DETS_PRE;
            cnt_reg   <= pre_len;
          end else begin
            cnt_reg <= cnt_reg + 2'h1;
          end
        end
        DETS_PRE: begin
          // Precharge also follows the last column, keeping the spacing to the next request
          if (cnt_reg == DETS_ONE_T) begin
            if (req_reg.beats != 2'h0) begin
              req_reg.beats <= req_reg.beats - 2'h1;
              state_reg     <= DETS_CAS;
              cnt_reg       <= 2'h0;
            end else begin
              state_reg <= DETS_IDLE;
              done_reg  <= 1'b1;
            end
          end else begin
            cnt_reg <= cnt_reg - 2'h1;
          end
        end
        default: state_reg <= DETS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Pop and latch strobes
  // ----------------------------------------
  // Phase counts clocks from column start and saturates at three
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      phase_reg <= 2'h0;
    end else if (cas_start) begin
      phase_reg <= 2'h0;
    end else if (state_reg != DETS_IDLE && phase_reg != 2'h3) begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // Pop is registered off the same edge as the strobe state, so the aligned
  // setting uses the start term and the trailing one the first column cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pop_reg <= 1'b0;
    end else if (edo_strobe_timing_control_reg[DETS_B_POP_ALIGN]) begin
      pop_reg <= cas_start;
    end else begin
      pop_reg <= state_reg == DETS_CAS && phase_reg == 2'h0;
    end
  end

  // A latch delay longer than the access is simply not issued
  // The test setting wins over every timing choice
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      latch_reg <= 1'b0;
    end else if (edo_strobe_timing_control_reg[DETS_B_LATCH_HIGH]) begin
      latch_reg <= 1'b1;
    end else if (cas_start) begin
      latch_reg <= lat_delay == 2'h0;
    end else begin
      latch_reg <= state_reg != DETS_IDLE && lat_delay != 2'h0
                 && phase_reg + 2'h1 == lat_delay;
    end
  end

  // ----------------------------------------
  // Parity checking
  // ----------------------------------------
  // Global check, per-bank mask, or none, from the two aux bits
  // The mask is registered: a new setting applies one clock after the write
  logic [7:0] par_en_next;
  always_comb begin
    if (!aux_config_reg[DETS_B_PAR_GLOBAL_OFF]) begin
      par_en_next = 8'hff;
    end else if (aux_config_reg[DETS_B_PAR_BANK_EN]) begin
      par_en_next = ~bank_parity_disable_reg;
    end else begin
      par_en_next = 8'h00;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      par_en_reg  <= 8'h00;
      par_err_reg <= 1'b0;
    end else begin
      par_en_reg  <= par_en_next;
      // The error uses the same registered mask that the enable port shows
      par_err_reg <= i_parity_fail && state_reg != DETS_IDLE
                   && par_en_reg[req_reg.bank];
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Strobe follows the state register directly; pop and latch are flops
  assign o_rdata                    = rdata_reg;
  assign o_busy                     = state_reg != DETS_IDLE;
  assign o_done                     = done_reg;
  assign o_col_strobe_n             = state_reg != DETS_CAS;
  assign o_data_buffer_pop_strobe   = pop_reg;
  assign o_memory_data_latch_enable = latch_reg;
  assign o_bank_parity_enable       = par_en_reg;
  assign o_parity_error             = par_err_reg;
  // The cache sequencer outside reads this level; it is not timed here
  assign o_sram_write_first_4t      = edo_strobe_timing_control_reg[DETS_B_SRAM_WR4]
                                    && aux_config_reg[DETS_LSB_SRAM_FIRST +: 2] == DETS_SRAM_FIRST_3T;

endmodule
`default_nettype wire
